// ---- verilog/pirf_irq_flags.sv ----
// peripheral interrupt flag registers with apb slave and masked irq
`timescale 1ns/1ps
`default_nettype none
module pirf_irq_flags (
    // clock and reset
    input  wire logic                   clk_sys_i,
    input  wire logic                   rst_n_i,
    // apb slave
    input  wire logic                   psel_i,
    input  wire logic                   penable_i,
    input  wire logic                   pwrite_i,
    input  wire logic [7:0]             paddr_i,
    input  wire logic [31:0]            pwdata_i,
    input  wire logic [3:0]             pstrb_i,
    output logic      [31:0]            prdata_o,
    output logic                        pready_o,
    output logic                        pslverr_o,
    // peripheral events
    input  wire pirf_pkg::pirf_unit_ev_t unit1_ev_i,
    input  wire pirf_pkg::pirf_unit_ev_t unit2_ev_i,
    input  wire pirf_pkg::pirf_misc_ev_t misc_ev_i,
    // interrupt
    output logic                        irq_o
);

    // bus phase and decode
    logic        setup_w;       // setup cycle of a transfer
    logic        done_w;        // access edge at which transfer ends
    logic        wr_en_w;       // write takes effect this edge
    logic        hit_cc_w;      // capture flag register addressed
    logic        hit_mow_w;     // second flag register addressed
    logic        hit_ccm_w;     // capture mask addressed
    logic        hit_mowm_w;    // second mask addressed
    logic        hit_mode_w;    // mode register addressed
    logic        mapped_w;      // any register addressed
    logic [7:0]  wbyte_w;       // written byte
    logic [7:0]  rbyte_w;       // selected read byte
    logic [31:0] rdata_w;       // padded read word

    // registers
    logic [31:0] prdata_r;      // read data to bus
    logic        pready_r;      // ready to bus
    logic        pslverr_r;     // error to bus
    logic        irq_r;         // interrupt output
    logic [7:0]  cc_mask_r;     // enables for capture flags
    logic [7:0]  mow_mask_r;    // enables for second flags
    logic [7:0]  mode_r;        // unit mode selects
    logic        irq_nxt;       // next interrupt level

    // flags and their controls, second register in the upper byte
    logic [15:0] flags_q;       // all flag bits
    logic [15:0] set_vec;       // hardware set per bit
    logic [15:0] wr_vec;        // software write per bit
    logic [15:0] wdata_vec;     // software value per bit
    // implemented bits, fixed at elaboration for the generate below
    localparam logic [15:0] IMPL_VEC = {pirf_pkg::PIRF_MOW_IMPL,
                                        pirf_pkg::PIRF_CC_IMPL};

    // unit event selection
    logic [1:0]  mode_u1_w;     // unit one mode
    logic [1:0]  mode_u2_w;     // unit two mode
    logic        u1_fall_w;     // unit one output trailing edge
    logic        u2_fall_w;     // unit two output trailing edge
    logic        cwg_rise_w;    // shutdown entry
    logic        u1_set_w;      // unit one qualifying event
    logic        u2_set_w;      // unit two qualifying event

    // apb phases
    assign setup_w = psel_i & ~penable_i;
    assign done_w  = psel_i & penable_i & pready_r;
    assign wr_en_w = done_w & pwrite_i & pstrb_i[pirf_pkg::PIRF_LANE0];
    assign wbyte_w = pwdata_i[pirf_pkg::PIRF_DW-1:0];

    // address decode
    assign hit_cc_w   = (paddr_i == pirf_pkg::PIRF_OFS_CC_FLAGS);
    assign hit_mow_w  = (paddr_i == pirf_pkg::PIRF_OFS_MOW_FLAGS);
    assign hit_ccm_w  = (paddr_i == pirf_pkg::PIRF_OFS_CC_MASK);
    assign hit_mowm_w = (paddr_i == pirf_pkg::PIRF_OFS_MOW_MASK);
    assign hit_mode_w = (paddr_i == pirf_pkg::PIRF_OFS_MODE);
    assign mapped_w   = hit_cc_w | hit_mow_w | hit_ccm_w | hit_mowm_w
                      | hit_mode_w;

    // read mux, unimplemented bits come back as zero
    always_comb begin
        if (hit_cc_w) begin
            rbyte_w = flags_q[7:0] & pirf_pkg::PIRF_CC_IMPL;
        end else if (hit_mow_w) begin
            rbyte_w = flags_q[15:8] & pirf_pkg::PIRF_MOW_IMPL;
        end else if (hit_ccm_w) begin
            rbyte_w = cc_mask_r;
        end else if (hit_mowm_w) begin
            rbyte_w = mow_mask_r;
        end else if (hit_mode_w) begin
            rbyte_w = mode_r;
        end else begin
            rbyte_w = 8'h00;
        end
    end
    assign rdata_w = {{pirf_pkg::PIRF_PAD_W{1'b0}}, rbyte_w};

    // bus answer: ready in the first access cycle, data from setup
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r <= setup_w;
            if (setup_w) begin
                pslverr_r <= ~mapped_w;
                prdata_r  <= pwrite_i ? 32'h0000_0000 : rdata_w;
            end else if (done_w) begin
                pslverr_r <= 1'b0;
            end
        end
    end

    // mask and mode registers, unused bits never stored
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cc_mask_r  <= pirf_pkg::PIRF_MASK_RST;
            mow_mask_r <= pirf_pkg::PIRF_MASK_RST;
            mode_r     <= pirf_pkg::PIRF_MODE_RST;
        end else if (wr_en_w) begin
            if (hit_ccm_w) begin
                cc_mask_r <= wbyte_w & pirf_pkg::PIRF_CC_IMPL;
            end else if (hit_mowm_w) begin
                mow_mask_r <= wbyte_w & pirf_pkg::PIRF_MOW_IMPL;
            end else if (hit_mode_w) begin
                mode_r <= wbyte_w & pirf_pkg::PIRF_MODE_IMPL;
            end
        end
    end

    // mode fields per unit
    assign mode_u1_w = mode_r[pirf_pkg::PIRF_MODE_U1_LSB +:
                              pirf_pkg::PIRF_MODE_W];
    assign mode_u2_w = mode_r[pirf_pkg::PIRF_MODE_U2_LSB +:
                              pirf_pkg::PIRF_MODE_W];

    // trailing edge of unit one pulse-width output
    pirf_edge_det #(.FALLING(1'b1)) u_u1_fall (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .level_i   (unit1_ev_i.pwm_out),
        .edge_o    (u1_fall_w)
    );

    // trailing edge of unit two pulse-width output
    pirf_edge_det #(.FALLING(1'b1)) u_u2_fall (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .level_i   (unit2_ev_i.pwm_out),
        .edge_o    (u2_fall_w)
    );

    // entry into waveform generator shutdown
    pirf_edge_det #(.FALLING(1'b0)) u_cwg_rise (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .level_i   (misc_ev_i.shutdown_lvl),
        .edge_o    (cwg_rise_w)
    );

    // mode picks which unit event qualifies
    assign u1_set_w =
        (mode_u1_w == pirf_pkg::PIRF_MODE_CAPTURE) ? unit1_ev_i.capture :
        (mode_u1_w == pirf_pkg::PIRF_MODE_COMPARE) ? unit1_ev_i.compare :
        (mode_u1_w == pirf_pkg::PIRF_MODE_PWM)     ? u1_fall_w : 1'b0;
    assign u2_set_w =
        (mode_u2_w == pirf_pkg::PIRF_MODE_CAPTURE) ? unit2_ev_i.capture :
        (mode_u2_w == pirf_pkg::PIRF_MODE_COMPARE) ? unit2_ev_i.compare :
        (mode_u2_w == pirf_pkg::PIRF_MODE_PWM)     ? u2_fall_w : 1'b0;

    // set vector, no enable or mask takes part
    always_comb begin
        set_vec = 16'h0000;
        set_vec[pirf_pkg::PIRF_CC_U1_BIT] = u1_set_w;
        set_vec[pirf_pkg::PIRF_CC_U2_BIT] = u2_set_w;
        set_vec[pirf_pkg::PIRF_MOW_BASE + pirf_pkg::PIRF_MOW_NVM_BIT] =
            misc_ev_i.mem_done;
        set_vec[pirf_pkg::PIRF_MOW_BASE + pirf_pkg::PIRF_MOW_NCO_BIT] =
            misc_ev_i.rollover;
        set_vec[pirf_pkg::PIRF_MOW_BASE + pirf_pkg::PIRF_MOW_CWG_BIT] =
            cwg_rise_w;
    end

    // software write strobes and data per flag bit
    assign wr_vec    = {{8{wr_en_w & hit_mow_w}}, {8{wr_en_w & hit_cc_w}}};
    assign wdata_vec = {wbyte_w, wbyte_w};

    // one flag cell per implemented bit, others tied low
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_flag
            if (IMPL_VEC[gi]) begin : g_cell
                pirf_flag_cell u_cell (
                    .clk_sys_i (clk_sys_i),
                    .rst_n_i   (rst_n_i),
                    .set_i     (set_vec[gi]),
                    .wr_i      (wr_vec[gi]),
                    .wdata_i   (wdata_vec[gi]),
                    .q_o       (flags_q[gi])
                );
            end else begin : g_none
                assign flags_q[gi] = 1'b0;
            end
        end
    endgenerate

    // interrupt level, high while any unmasked flag is set
    assign irq_nxt = |(flags_q & {mow_mask_r, cc_mask_r});

    // registered interrupt output
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    // outputs straight from flops
    assign prdata_o  = prdata_r;
    assign pready_o  = pready_r;
    assign pslverr_o = pslverr_r;
    assign irq_o     = irq_r;

    // checks on the flag, interrupt and bus behaviour
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    cc_unused_zero_a: assert property (
        setup_w && !pwrite_i && hit_cc_w |=> prdata_o[7:2] == 6'h00
    ) else $error("capture flag unused bits not zero");

    unit2_capture_a: assert property (
        mode_u2_w == pirf_pkg::PIRF_MODE_CAPTURE && unit2_ev_i.capture
        |=> flags_q[pirf_pkg::PIRF_CC_U2_BIT]
    ) else $error("unit two capture did not set flag");

    unit1_pwm_a: assert property (
        mode_u1_w == pirf_pkg::PIRF_MODE_PWM && $fell(unit1_ev_i.pwm_out)
        |=> flags_q[pirf_pkg::PIRF_CC_U1_BIT]
    ) else $error("unit one trailing edge did not set flag");

    flag_sticky_a: assert property (
        flags_q[pirf_pkg::PIRF_CC_U1_BIT] && !(wr_en_w && hit_cc_w)
        |=> flags_q[pirf_pkg::PIRF_CC_U1_BIT]
    ) else $error("flag dropped without software write");

    set_unmasked_a: assert property (
        unit1_ev_i.compare && cc_mask_r == 8'h00
        && mode_u1_w == pirf_pkg::PIRF_MODE_COMPARE
        |=> flags_q[pirf_pkg::PIRF_CC_U1_BIT]
    ) else $error("masked compare event was not flagged");

    mem_done_a: assert property (
        misc_ev_i.mem_done
        |=> flags_q[pirf_pkg::PIRF_MOW_BASE + pirf_pkg::PIRF_MOW_NVM_BIT]
    ) else $error("memory done did not set flag");

    rollover_a: assert property (
        misc_ev_i.rollover
        |=> flags_q[pirf_pkg::PIRF_MOW_BASE + pirf_pkg::PIRF_MOW_NCO_BIT]
    ) else $error("rollover did not set flag");

    shutdown_a: assert property (
        $rose(misc_ev_i.shutdown_lvl)
        |=> flags_q[pirf_pkg::PIRF_MOW_BASE + pirf_pkg::PIRF_MOW_CWG_BIT]
    ) else $error("shutdown entry did not set flag");

    mow_unused_zero_a: assert property (
        setup_w && !pwrite_i && hit_mow_w
        |=> prdata_o[7:6] == 2'h0 && prdata_o[3:1] == 3'h0
    ) else $error("second flag unused bits not zero");

    sw_clear_a: assert property (
        wr_en_w && hit_mow_w && !pwdata_i[pirf_pkg::PIRF_MOW_NCO_BIT]
        && !misc_ev_i.rollover
        |=> !flags_q[pirf_pkg::PIRF_MOW_BASE + pirf_pkg::PIRF_MOW_NCO_BIT]
    ) else $error("software write of zero did not clear");

    set_wins_a: assert property (
        wr_en_w && hit_mow_w && !pwdata_i[pirf_pkg::PIRF_MOW_NVM_BIT]
        && misc_ev_i.mem_done
        |=> flags_q[pirf_pkg::PIRF_MOW_BASE + pirf_pkg::PIRF_MOW_NVM_BIT]
    ) else $error("clear beat a simultaneous set");

    irq_follow_a: assert property (
        irq_nxt |=> irq_o ##0 $past(irq_nxt)
    ) else $error("interrupt did not follow unmasked flag");

    ready_setup_a: assert property (
        setup_w |=> pready_o
    ) else $error("ready missing in first access cycle");

    unmapped_err_a: assert property (
        setup_w && !mapped_w |=> pslverr_o
    ) else $error("unmapped address not refused");

    // reset leaves every flag and the interrupt clear
    reset_clear_a: assert property (
        $rose(rst_n_i)
        |-> flags_q == {pirf_pkg::PIRF_FLAG_RST, pirf_pkg::PIRF_FLAG_RST}
        && !irq_o
    ) else $error("flags not clear after reset");

    unit1_capture_a: assert property (
        mode_u1_w == pirf_pkg::PIRF_MODE_CAPTURE && unit1_ev_i.capture
        |=> flags_q[pirf_pkg::PIRF_CC_U1_BIT]
    ) else $error("unit one capture did not set flag");

    unit2_pwm_a: assert property (
        mode_u2_w == pirf_pkg::PIRF_MODE_PWM && $fell(unit2_ev_i.pwm_out)
        |=> flags_q[pirf_pkg::PIRF_CC_U2_BIT]
    ) else $error("unit two trailing edge did not set flag");

    // unit one switched off never raises its flag
    unit1_off_a: assert property (
        mode_u1_w == pirf_pkg::PIRF_MODE_OFF
        && !flags_q[pirf_pkg::PIRF_CC_U1_BIT] && !(wr_en_w && hit_cc_w)
        |=> !flags_q[pirf_pkg::PIRF_CC_U1_BIT]
    ) else $error("unit one flag set while off");

    mow_sticky_a: assert property (
        flags_q[pirf_pkg::PIRF_MOW_BASE + pirf_pkg::PIRF_MOW_NVM_BIT]
        && !(wr_en_w && hit_mow_w)
        |=> flags_q[pirf_pkg::PIRF_MOW_BASE + pirf_pkg::PIRF_MOW_NVM_BIT]
    ) else $error("memory flag dropped without software write");

    // main scenarios
    capture_seen_c: cover property (
        unit1_ev_i.capture ##1 flags_q[pirf_pkg::PIRF_CC_U1_BIT]
    );
    clear_collide_c: cover property (
        wr_en_w && hit_mow_w && misc_ev_i.mem_done
    );
    irq_raise_c: cover property ($rose(irq_o));
    unmapped_c: cover property (done_w && pslverr_o);
    pwm_trail_c: cover property (
        mode_u1_w == pirf_pkg::PIRF_MODE_PWM && u1_fall_w
    );

endmodule : pirf_irq_flags
`default_nettype wire

// ---- include/pirf_pkg.sv ----
// package: register map, field layout, modes and event carriers
package pirf_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] PIRF_OFS_CC_FLAGS  = 8'h00;
    localparam logic [7:0] PIRF_OFS_MOW_FLAGS = 8'h04;
    localparam logic [7:0] PIRF_OFS_CC_MASK   = 8'h08;
    localparam logic [7:0] PIRF_OFS_MOW_MASK  = 8'h0C;
    localparam logic [7:0] PIRF_OFS_MODE      = 8'h10;

    // data layout: one byte of register in the low lane
    localparam int PIRF_DW    = 8;
    localparam int PIRF_PAD_W = 24;
    localparam int PIRF_LANE0 = 0;
    localparam int PIRF_MOW_BASE = 8;

    // capture/compare flag register bits
    localparam int PIRF_CC_U1_BIT = 0;
    localparam int PIRF_CC_U2_BIT = 1;
    // memory/oscillator/waveform flag register bits
    localparam int PIRF_MOW_CWG_BIT = 0;
    localparam int PIRF_MOW_NCO_BIT = 4;
    localparam int PIRF_MOW_NVM_BIT = 5;

    // implemented bit masks, all else reads zero
    localparam logic [7:0] PIRF_CC_IMPL  = 8'h03;
    localparam logic [7:0] PIRF_MOW_IMPL = 8'h31;

    // reset values
    localparam logic [7:0] PIRF_FLAG_RST = 8'h00;
    localparam logic [7:0] PIRF_MASK_RST = 8'h00;
    localparam logic [7:0] PIRF_MODE_RST = 8'h00;

    // unit mode field, two bits per unit
    localparam int PIRF_MODE_W      = 2;
    localparam int PIRF_MODE_U1_LSB = 0;
    localparam int PIRF_MODE_U2_LSB = 2;
    localparam logic [7:0] PIRF_MODE_IMPL = 8'h0F;

    // unit mode codes
    localparam logic [1:0] PIRF_MODE_CAPTURE = 2'h0;
    localparam logic [1:0] PIRF_MODE_COMPARE = 2'h1;
    localparam logic [1:0] PIRF_MODE_PWM     = 2'h2;
    localparam logic [1:0] PIRF_MODE_OFF     = 2'h3;

    // events of one capture/compare/pulse-width unit
    typedef struct packed {
        logic capture;   // one-cycle pulse on a capture
        logic compare;   // one-cycle pulse on a compare match
        logic pwm_out;   // pulse-width output level
    } pirf_unit_ev_t;

    // events of memory, oscillator and waveform generator
    typedef struct packed {
        logic mem_done;      // one-cycle pulse, operation complete
        logic rollover;      // one-cycle pulse, accumulator wrap
        logic shutdown_lvl;  // level, high while in shutdown
    } pirf_misc_ev_t;

endpackage : pirf_pkg

// ---- verilog/pirf_edge_det.sv ----
// single edge detector on a same-clock level
`timescale 1ns/1ps
`default_nettype none
module pirf_edge_det #(
    parameter bit FALLING = 1'b0   // 1 detects falling, 0 rising
) (
    // clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    // level in, edge out
    input  wire logic level_i,
    output logic      edge_o
);

    logic prev_r;   // level one cycle ago

    // remember previous level
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= level_i;
        end
    end

    // edge of the chosen polarity, same cycle as the change
    assign edge_o = FALLING ? (prev_r & ~level_i) : (~prev_r & level_i);

endmodule : pirf_edge_det
`default_nettype wire

// ---- verilog/pirf_flag_cell.sv ----
// one sticky flag bit, software writable, hardware settable
`timescale 1ns/1ps
`default_nettype none
module pirf_flag_cell (
    // clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    // hardware set and software write
    input  wire logic set_i,
    input  wire logic wr_i,
    input  wire logic wdata_i,
    // flag value
    output logic      q_o
);

    logic flag_r;     // stored flag
    logic flag_nxt;   // next flag value

    // set wins over a written zero so no event is lost
    assign flag_nxt = set_i | (wr_i ? wdata_i : flag_r);

    // flag store, cleared by every reset
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign q_o = flag_r;

endmodule : pirf_flag_cell
`default_nettype wire

// ---- testbench/pirf_ev_src.sv ----
// event source model for the peripheral side of the flag block
`timescale 1ns/1ps
`default_nettype none
module pirf_ev_src (
    // clock
    input  wire logic                    clk_sys_i,
    // event lines toward the flag block
    output wire pirf_pkg::pirf_unit_ev_t unit1_ev_o,
    output wire pirf_pkg::pirf_unit_ev_t unit2_ev_o,
    output wire pirf_pkg::pirf_misc_ev_t misc_ev_o
);
    // one bit per event line: {unit one, unit two, misc}, all idle
    logic [8:0] ev_r = 9'h000;

    // struct order is capture, compare, pwm_out (and done, wrap, shutdown)
    assign unit1_ev_o = pirf_pkg::pirf_unit_ev_t'(ev_r[8:6]);
    assign unit2_ev_o = pirf_pkg::pirf_unit_ev_t'(ev_r[5:3]);
    assign misc_ev_o  = pirf_pkg::pirf_misc_ev_t'(ev_r[2:0]);

    // one-cycle high on a line; on pwm_out the fall is the trailing
    // edge, on shutdown_lvl the rise is a brief shutdown entry
    task automatic fire(input int idx);
        @(posedge clk_sys_i);
        ev_r[idx] <= 1'b1;
        @(posedge clk_sys_i);
        ev_r[idx] <= 1'b0;
    endtask : fire
endmodule : pirf_ev_src
`default_nettype wire

// ---- testbench/pirf_irq_flags_tb.sv ----
// self-checking bench for the peripheral interrupt flag block
`timescale 1ns/1ps
`default_nettype none
module pirf_irq_flags_tb;
    logic                    clk_sys_i = 1'b0;   // system clock
    logic                    rst_n_i   = 1'b0;   // async reset, active low
    logic                    psel      = 1'b0;   // apb request
    logic                    penable   = 1'b0;
    logic                    pwrite    = 1'b0;
    logic [7:0]              paddr     = 8'h00;
    logic [31:0]             pwdata    = 32'h0000_0000;
    logic [3:0]              pstrb     = 4'h0;
    logic [31:0]             prdata;             // apb answer
    logic                    pready;
    logic                    pslverr;
    logic                    irq;                // interrupt level
    wire pirf_pkg::pirf_unit_ev_t unit1_ev;      // event lines
    wire pirf_pkg::pirf_unit_ev_t unit2_ev;
    wire pirf_pkg::pirf_misc_ev_t misc_ev;
    int                      n_fail    = 0;      // mismatches
    int                      checks    = 0;      // comparisons
    localparam logic [7:0] CC   = pirf_pkg::PIRF_OFS_CC_FLAGS;
    localparam logic [7:0] MOW  = pirf_pkg::PIRF_OFS_MOW_FLAGS;
    localparam logic [7:0] CCM  = pirf_pkg::PIRF_OFS_CC_MASK;
    localparam logic [7:0] MOWM = pirf_pkg::PIRF_OFS_MOW_MASK;
    localparam logic [7:0] MODE = pirf_pkg::PIRF_OFS_MODE;

    // 250 mhz clock
    always #2 clk_sys_i = ~clk_sys_i;

    pirf_irq_flags dut (
        .clk_sys_i (clk_sys_i), .rst_n_i (rst_n_i),
        .psel_i (psel), .penable_i (penable), .pwrite_i (pwrite),
        .paddr_i (paddr), .pwdata_i (pwdata), .pstrb_i (pstrb),
        .prdata_o (prdata), .pready_o (pready), .pslverr_o (pslverr),
        .unit1_ev_i (unit1_ev), .unit2_ev_i (unit2_ev),
        .misc_ev_i (misc_ev), .irq_o (irq)
    );

    pirf_ev_src src (
        .clk_sys_i (clk_sys_i), .unit1_ev_o (unit1_ev),
        .unit2_ev_o (unit2_ev), .misc_ev_o (misc_ev)
    );

    // compare and count
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one apb transfer; waits for pready, bounded
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [7:0] wd, input logic [3:0] st,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h00_0000, wd};
        pstrb   <= st;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        // pready is read as sampled at each rising edge
        @(posedge clk_sys_i);
        while (pready !== 1'b1 && n < 16) begin
            n++;
            @(posedge clk_sys_i);
        end
        if (pready !== 1'b1) check("pready", {31'h0, pready}, 32'h1);
        rd = prdata;   // taken at the completing edge
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, 4'h1, rd, err);
    endtask : wr8

    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [7:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 8'h00, 4'h0, rd, err);
        check(what, rd, {24'h00_0000, exp});
    endtask : rd_chk

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : idle

    // every register zero after reset, unmapped place refused
    task automatic t_reset_values;
        logic [7:0]  ofs [5];
        logic [31:0] rd;
        logic        err;
        ofs = '{CC, MOW, CCM, MOWM, MODE};
        foreach (ofs[i]) rd_chk("reset value", ofs[i], 8'h00);
        apb(1'b0, 8'h14, 8'h00, 4'h0, rd, err);
        check("unmapped error", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
        check("irq after reset", {31'h0, irq}, 32'h0);
    endtask : t_reset_values

    // writable flags, unimplemented bits stay zero, strobe off ignored
    task automatic t_unimpl;
        logic [31:0] rd;
        logic        err;
        wr8(CC, 8'hFF);
        rd_chk("cc write ones", CC, 8'h03);
        wr8(MOW, 8'hFF);
        rd_chk("mow write ones", MOW, 8'h31);
        apb(1'b1, CC, 8'h00, 4'h0, rd, err);
        rd_chk("cc strobe off", CC, 8'h03);
        wr8(CC, 8'h00);
        wr8(MOW, 8'h00);
        rd_chk("cc write zero", CC, 8'h00);
        rd_chk("mow write zero", MOW, 8'h00);
    endtask : t_unimpl

    // each mode code on each unit: own event sets, foreign one ignored
    task automatic t_modes;
        logic [1:0] codes [4];
        logic [7:0] mv;
        int         base;
        codes = '{pirf_pkg::PIRF_MODE_CAPTURE, pirf_pkg::PIRF_MODE_COMPARE,
                  pirf_pkg::PIRF_MODE_PWM, pirf_pkg::PIRF_MODE_OFF};
        for (int u = 0; u < 2; u++) begin
            base = (u == 0) ? 8 : 5;
            for (int m = 0; m < 4; m++) begin
                mv = 8'h00;
                mv[2*u +: 2] = codes[m];
                wr8(MODE, mv);
                src.fire(base - ((m + 1) % 3));
                idle(3);
                rd_chk("cc foreign event", CC, 8'h00);
                if (m < 3) begin
                    src.fire(base - m);
                    idle(3);
                    rd_chk("cc own event", CC, 8'(1 << u));
                    wr8(CC, 8'h00);
                end
            end
        end
        wr8(MODE, 8'h00);
    endtask : t_modes

    // memory done, rollover, shutdown entry; sticky until written zero
    task automatic t_misc;
        logic [7:0] ex [3];
        ex = '{8'h20, 8'h10, 8'h01};
        for (int k = 0; k < 3; k++) begin
            src.fire(2 - k);
            idle(3);
            rd_chk("mow event", MOW, ex[k]);
            idle(20);
            rd_chk("mow sticky", MOW, ex[k]);
            wr8(MOW, 8'h00);
            rd_chk("mow cleared", MOW, 8'h00);
        end
    endtask : t_misc

    // interrupt raised, masked, cleared
    task automatic t_irq;
        wr8(CC, 8'h00);
        wr8(CCM, 8'h01);
        idle(2);
        check("irq clean enable", {31'h0, irq}, 32'h0);
        src.fire(8);
        idle(3);
        check("irq unmasked", {31'h0, irq}, 32'h1);
        wr8(CCM, 8'h00);
        idle(2);
        check("irq masked", {31'h0, irq}, 32'h0);
        rd_chk("cc flag under mask", CC, 8'h01);
        wr8(CCM, 8'h01);
        idle(2);
        check("irq re-enabled", {31'h0, irq}, 32'h1);
        wr8(CC, 8'h00);
        idle(2);
        check("irq flag cleared", {31'h0, irq}, 32'h0);
        wr8(MOWM, 8'h20);
        src.fire(2);
        idle(3);
        check("irq memory done", {31'h0, irq}, 32'h1);
        wr8(MOW, 8'h00);
        idle(2);
        check("irq memory cleared", {31'h0, irq}, 32'h0);
        wr8(CCM, 8'h00);
        wr8(MOWM, 8'h00);
    endtask : t_irq

    // event lands on the edge that commits a written zero
    task automatic t_race;
        fork
            wr8(CC, 8'h00);
            begin
                @(posedge clk_sys_i);
                src.fire(8);
            end
        join
        idle(2);
        rd_chk("set beats clear", CC, 8'h01);
        wr8(CC, 8'h00);
        fork
            wr8(MOW, 8'h00);
            begin
                @(posedge clk_sys_i);
                src.fire(2);
            end
        join
        idle(2);
        rd_chk("mow set beats clear", MOW, 8'h20);
        wr8(MOW, 8'h00);
    endtask : t_race

    // reset in mid-run clears flags and masks
    task automatic t_midreset;
        wr8(CCM, 8'h01);
        src.fire(8);
        src.fire(1);
        idle(3);
        check("irq before reset", {31'h0, irq}, 32'h1);
        rst_n_i <= 1'b0;
        idle(2);
        check("irq in reset", {31'h0, irq}, 32'h0);
        rst_n_i <= 1'b1;
        rd_chk("cc after reset", CC, 8'h00);
        rd_chk("mow after reset", MOW, 8'h00);
        rd_chk("mask after reset", CCM, 8'h00);
    endtask : t_midreset

    // verdict and end of run
    task automatic report_and_stop;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    // main sequence
    initial begin
        repeat (4) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        t_reset_values();
        t_unimpl();
        t_modes();
        t_misc();
        t_irq();
        t_race();
        t_midreset();
        report_and_stop();
    end

    // watchdog, about twenty-four times the expected run
    initial begin
        #40000;
        check("watchdog", 32'h1, 32'h0);
        report_and_stop();
    end
endmodule : pirf_irq_flags_tb
`default_nettype wire
